// ===== logic/tbu_pkg.sv
// constants and types of the program flow trace buffer
// What this block does
// - trace writes beat processor SRAM accesses
// - one two-word packet per non-sequential jump, except during word0 or the cycle an auto stop hits
// - taken branches and exception entry both trigger
// - packets written only while enable is one
// - enable writes take effect at once
// - auto stop clears enable at watermark
// - without auto stop, pointer wraps and overwrites
// - registers decoded at fixed base plus offset
// - position register shows pointer and wrap flag
// - flow register: watermark, auto stop, auto halt
// - read-only location register gives SRAM address
// - processor keeps using SRAM between trace writes
// - region start and size set by software
package tbu_pkg;
    // fixed system address of the register block
    localparam logic [31:0] TBU_BASE_ADDR = 32'h4100_6000;
    // register offsets from the base
    localparam logic [3:0] OFF_POSITION = 4'h0;
    localparam logic [3:0] OFF_CONTROL = 4'h4;
    localparam logic [3:0] OFF_FLOW = 4'h8;
    localparam logic [3:0] OFF_LOCATION = 4'hc;
    // pointer field, in eight-byte packet units
    localparam int PTR_LSB = 3;
    localparam int PTR_MSB = 14;
    localparam int WRAP_BIT = 2;
    // control register fields
    localparam int EN_BIT = 31;
    localparam int MASK_MSB = 3;
    // flow register fields
    localparam int STOP_BIT = 0;
    localparam int HALT_BIT = 1;
    // reset values
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [11:0] WM_RST = 12'h000;
    // where the trace SRAM sits, a plain default
    localparam logic [31:0] SRAM_LOC = 32'h2000_0000;
    // trace writer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WORD0 = 3'b010,
        ST_WORD1 = 3'b100
    } tbu_state_t;
endpackage : tbu_pkg

// ===== logic/tbu_top.sv
// program flow trace buffer: trace writer, SRAM arbiter, APB registers
`timescale 1ns/1ps
module tbu_top
    import tbu_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // execution trace from the core
    input wire logic TRACE_BRANCH_IN,
    input wire logic TRACE_EXC_IN,
    input wire logic [31:0] TRACE_SRC_IN,
    input wire logic [31:0] TRACE_DST_IN,
    // processor SRAM request
    input wire logic CPU_REQ_IN,
    input wire logic CPU_WE_IN,
    input wire logic [3:0] CPU_BE_IN,
    input wire logic [12:0] CPU_ADDR_IN,
    input wire logic [31:0] CPU_WDATA_IN,
    output logic CPU_ACK_OUT,
    output logic [31:0] CPU_RDATA_OUT,
    // shared SRAM port
    output logic SRAM_EN_OUT,
    output logic SRAM_WE_OUT,
    output logic [3:0] SRAM_BE_OUT,
    output logic [12:0] SRAM_ADDR_OUT,
    output logic [31:0] SRAM_WDATA_OUT,
    input wire logic [31:0] SRAM_RDATA_IN,
    // status to the core
    output logic TRACE_ON_OUT,
    output logic HALT_REQ_OUT
);

    // region size mask in packet units, 2 << m units
    function automatic logic [11:0] unit_mask(input logic [3:0] m);
        unit_mask = (12'h002 << m) - 12'h001;
    endfunction : unit_mask

    // trace writer state
    tbu_state_t state_reg;
    tbu_state_t state_next;

    // software visible state
    logic en_reg; // trace enable
    logic en_next;
    logic [3:0] mask_reg; // region size code
    logic [3:0] mask_next;
    logic [11:0] ptr_reg; // write pointer, packet units
    logic [11:0] ptr_next;
    logic wrap_reg; // pointer has rolled over
    logic wrap_next;
    logic [11:0] wm_reg; // watermark, packet units
    logic [11:0] wm_next;
    logic stop_reg; // auto_stop_on_threshold
    logic stop_next;
    logic halt_en_reg; // auto_halt_on_threshold
    logic halt_en_next;
    logic start_reg; // next packet is first after enable
    logic start_next;

    // packet being written
    logic [31:0] word0_reg;
    logic [31:0] word1_reg;

    // processor access pipeline
    logic own_reg; // SRAM cycle issued for processor
    logic wait_reg; // read data arriving
    logic ack_reg;
    logic [31:0] rdata_reg;

    // SRAM command flops
    logic sram_en_reg;
    logic sram_we_reg;
    logic [3:0] sram_be_reg;
    logic [12:0] sram_addr_reg;
    logic [31:0] sram_wdata_reg;

    // apb answer flops
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic halt_reg;

    // apb decode
    wire setup = PSEL_IN & ~PENABLE_IN;
    wire access = PSEL_IN & PENABLE_IN & pready_reg;
    wire wr = access & PWRITE_IN;
    wire hit = (PADDR_IN[31:4] == TBU_BASE_ADDR[31:4]);
    wire mapped = hit & (PADDR_IN[1:0] == 2'b00);
    wire sel_pos = mapped & (PADDR_IN[3:0] == OFF_POSITION);
    wire sel_ctl = mapped & (PADDR_IN[3:0] == OFF_CONTROL);
    wire sel_flow = mapped & (PADDR_IN[3:0] == OFF_FLOW);
    wire sel_loc = mapped & (PADDR_IN[3:0] == OFF_LOCATION);
    wire wr_pos = wr & sel_pos;
    wire wr_ctl = wr & sel_ctl;
    wire wr_flow = wr & sel_flow;

    // read mux, built in the setup cycle
    wire [31:0] pos_val = {17'h0, ptr_reg, wrap_reg, 2'b00};
    wire [31:0] ctl_val = {en_reg, 27'h0, mask_reg};
    wire [31:0] flow_val = {17'h0, wm_reg, 1'b0, halt_en_reg,
        stop_reg};
    wire [31:0] rd_mux =
        sel_pos ? pos_val :
        sel_ctl ? ctl_val :
        sel_flow ? flow_val :
        sel_loc ? SRAM_LOC :
        32'h0;

    // pointer advance inside the region
    wire [11:0] m = unit_mask(mask_reg);
    wire [11:0] ptr_inc = ptr_reg + 12'h001;
    // upper bits fix the region start, low bits walk it
    wire [11:0] ptr_adv = (ptr_reg & ~m) | (ptr_inc & m);
    wire rolled = ((ptr_inc & m) == 12'h000);
    wire adv = (state_reg == ST_WORD1);
    wire at_wm = adv & (ptr_adv == wm_reg);
    wire stop_hit = at_wm & stop_reg;

    // packet trigger
    wire ev = TRACE_BRANCH_IN | TRACE_EXC_IN;
    // a jump is caught while enabled unless word0 is going out or a stop hits
    wire take = ev & en_reg & (state_reg != ST_WORD0) &
        ~stop_hit;

    // arbitration: trace owns the SRAM in its two write cycles
    wire trace_use = (state_reg == ST_WORD0) |
        (state_reg == ST_WORD1);
    wire cpu_busy = own_reg | wait_reg | ack_reg;
    wire grant = CPU_REQ_IN & ~trace_use & ~cpu_busy;

    // software write wins over auto stop on the same edge
    assign en_next = wr_ctl ? PWDATA_IN[EN_BIT] :
        (stop_hit ? 1'b0 : en_reg);
    assign mask_next = wr_ctl ? PWDATA_IN[MASK_MSB:0] : mask_reg;
    assign ptr_next = wr_pos ? PWDATA_IN[PTR_MSB:PTR_LSB] :
        (adv ? ptr_adv : ptr_reg);
    // hardware set wins over a software clear
    assign wrap_next = (adv & rolled) |
        (wr_pos ? PWDATA_IN[WRAP_BIT] : wrap_reg);
    assign wm_next = wr_flow ? PWDATA_IN[PTR_MSB:PTR_LSB] : wm_reg;
    assign stop_next = wr_flow ? PWDATA_IN[STOP_BIT] : stop_reg;
    assign halt_en_next = wr_flow ? PWDATA_IN[HALT_BIT] : halt_en_reg;
    // mark the first packet after each enable
    assign start_next = (en_next & ~en_reg) ? 1'b1 :
        (take ? 1'b0 : start_reg);

    // SRAM command for this cycle
    wire [12:0] trace_addr = {ptr_reg, (state_reg == ST_WORD1)};
    wire [31:0] trace_data = (state_reg == ST_WORD0) ? word0_reg :
        word1_reg;
    wire cmd_en = trace_use | grant;
    wire cmd_we = trace_use | CPU_WE_IN;
    wire [3:0] cmd_be = trace_use ? 4'hf : CPU_BE_IN;
    wire [12:0] cmd_addr = trace_use ? trace_addr : CPU_ADDR_IN;
    wire [31:0] cmd_wdata = trace_use ? trace_data : CPU_WDATA_IN;

    // trace writer sequencing
    always_comb
    begin
        state_next = ST_IDLE;
        case (state_reg)
            ST_IDLE:
            begin
                // wait for a jump while enabled
                state_next = take ? ST_WORD0 : ST_IDLE;
            end
            ST_WORD0:
            begin
                // first word out, second follows
                state_next = ST_WORD1;
            end
            ST_WORD1:
            begin
                // back to back jumps chain straight on
                state_next = take ? ST_WORD0 : ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // control and pointer registers
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            state_reg <= ST_IDLE;
            en_reg <= 1'b0;
            mask_reg <= MASK_RST;
            ptr_reg <= PTR_RST;
            wrap_reg <= 1'b0;
            wm_reg <= WM_RST;
            stop_reg <= 1'b0;
            halt_en_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            en_reg <= en_next;
            mask_reg <= mask_next;
            ptr_reg <= ptr_next;
            wrap_reg <= wrap_next;
            wm_reg <= wm_next;
            stop_reg <= stop_next;
            halt_en_reg <= halt_en_next;
            start_reg <= start_next;
        end
    end

    // packet capture: source with exception flag, then target
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            word0_reg <= 32'h0;
            word1_reg <= 32'h0;
        end
        else if (take)
        begin
            // bit 0 of a thumb address is free for flags
            word0_reg <= {TRACE_SRC_IN[31:1], TRACE_EXC_IN};
            word1_reg <= {TRACE_DST_IN[31:1], start_reg};
        end
    end

    // SRAM command flops, one cycle after the decision
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            sram_en_reg <= 1'b0;
            sram_we_reg <= 1'b0;
            sram_be_reg <= 4'h0;
            sram_addr_reg <= 13'h0;
            sram_wdata_reg <= 32'h0;
        end
        else
        begin
            sram_en_reg <= cmd_en;
            sram_we_reg <= cmd_we & cmd_en;
            sram_be_reg <= cmd_be;
            sram_addr_reg <= cmd_addr;
            sram_wdata_reg <= cmd_wdata;
        end
    end

    // processor pipeline: issue, data, ack
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            own_reg <= 1'b0;
            wait_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            own_reg <= grant;
            wait_reg <= own_reg;
            ack_reg <= wait_reg;
            // SRAM data is valid the cycle after its enable
            if (wait_reg)
            begin
                rdata_reg <= SRAM_RDATA_IN;
            end
        end
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end
        else
        begin
            pready_reg <= setup;
            if (setup)
            begin
                // unmapped or misaligned answers with an error
                pslverr_reg <= ~mapped;
                prdata_reg <= PWRITE_IN ? 32'h0 : rd_mux;
            end
        end
    end

    // halt request pulse when the pointer meets the watermark
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            halt_reg <= 1'b0;
        end
        else
        begin
            halt_reg <= at_wm & halt_en_reg;
        end
    end

    // outputs straight from flops
    assign PRDATA_OUT = prdata_reg;
    assign PREADY_OUT = pready_reg;
    assign PSLVERR_OUT = pslverr_reg;
    assign CPU_ACK_OUT = ack_reg;
    assign CPU_RDATA_OUT = rdata_reg;
    assign SRAM_EN_OUT = sram_en_reg;
    assign SRAM_WE_OUT = sram_we_reg;
    assign SRAM_BE_OUT = sram_be_reg;
    assign SRAM_ADDR_OUT = sram_addr_reg;
    assign SRAM_WDATA_OUT = sram_wdata_reg;
    assign TRACE_ON_OUT = en_reg;
    assign HALT_REQ_OUT = halt_reg;

endmodule : tbu_top

// ===== dv/tbu_sram_model.sv
// shared SRAM model with a one-cycle synchronous read
`timescale 1ns/1ps
module tbu_sram_model (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [3:0] be_in,
    input wire logic [12:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);
    // whole array, also the debugger's view of the packets
    logic [31:0] mem [8192];
    initial rdata_out = 32'h0;
    // byte-lane writes; idle cycles flip the data so stale reads show
    always @(posedge clk_in)
    begin
        if (en_in && we_in)
        begin
            for (int i = 0; i < 4; i++)
                if (be_in[i]) mem[addr_in][8*i +: 8] <= wdata_in[8*i +: 8];
        end
        rdata_out <= (en_in && !we_in) ? mem[addr_in] : ~rdata_out;
    end
endmodule : tbu_sram_model

// ===== dv/tbu_sva.sv
// assertions on the trace buffer ports
`timescale 1ns/1ps
module tbu_sva (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic TRACE_BRANCH_IN,
    input wire logic TRACE_EXC_IN,
    input wire logic [31:0] TRACE_SRC_IN,
    input wire logic [31:0] TRACE_DST_IN,
    input wire logic CPU_REQ_IN,
    input wire logic CPU_WE_IN,
    input wire logic CPU_ACK_OUT,
    input wire logic [31:0] CPU_RDATA_OUT,
    input wire logic SRAM_EN_OUT,
    input wire logic SRAM_WE_OUT,
    input wire logic [12:0] SRAM_ADDR_OUT,
    input wire logic [31:0] SRAM_WDATA_OUT,
    input wire logic [31:0] SRAM_RDATA_IN,
    input wire logic TRACE_ON_OUT,
    input wire logic HALT_REQ_OUT
);
    wire logic ev = TRACE_BRANCH_IN | TRACE_EXC_IN; // any jump
    logic [3:0] hist_reg; // jumps of the last four cycles
    logic [2:0] quiet_reg; // idle cycles, saturating at seven
    // history keeps the writer-busy cases out of the timing checks
    always_ff @(posedge SYS_CLK_IN)
    begin
        hist_reg <= RST_IN ? 4'h0 : {hist_reg[2:0], ev};
        quiet_reg <= (RST_IN || TRACE_ON_OUT || CPU_REQ_IN) ? 3'h0
            : quiet_reg + {2'h0, quiet_reg != 3'h7};
    end
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    a_ready_now: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
        else $error("access without ready");
    a_bad_addr: assert property (PSEL_IN && PENABLE_IN &&
        PADDR_IN[31:4] != 28'h4100600 |-> PSLVERR_OUT)
        else $error("unmapped access not refused");
    a_word_zero: assert property (ev && TRACE_ON_OUT &&
        hist_reg == 4'h0 |-> ##2 SRAM_WE_OUT && !SRAM_ADDR_OUT[0] &&
        SRAM_WDATA_OUT == {$past(TRACE_SRC_IN, 2) >> 1, $past(TRACE_EXC_IN, 2)})
        else $error("packet head wrong");
    a_word_one: assert property (ev && TRACE_ON_OUT &&
        hist_reg == 4'h0 |-> ##3 SRAM_WE_OUT && SRAM_ADDR_OUT[0] &&
        SRAM_WDATA_OUT[31:1] == $past(TRACE_DST_IN, 3) >> 1)
        else $error("packet tail wrong");
    a_off_quiet: assert property (quiet_reg > 3'h3 |-> !SRAM_EN_OUT)
        else $error("SRAM used while off");
    a_cpu_fast: assert property (CPU_REQ_IN && quiet_reg > 3'h3 &&
        !TRACE_ON_OUT |-> ##3 CPU_ACK_OUT)
        else $error("idle cpu access late");
    a_cpu_data: assert property (CPU_ACK_OUT && !CPU_WE_IN |->
        CPU_RDATA_OUT == $past(SRAM_RDATA_IN))
        else $error("cpu read data wrong");
    a_halt_pulse: assert property (HALT_REQ_OUT |=> !HALT_REQ_OUT)
        else $error("halt request too long");
    c_packet: cover property (ev && TRACE_ON_OUT ##2 SRAM_WE_OUT);
    c_halt: cover property (HALT_REQ_OUT);
    c_refused: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule : tbu_sva
bind tbu_top tbu_sva chk (.SYS_CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN,
    .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .TRACE_BRANCH_IN, .TRACE_EXC_IN,
    .TRACE_SRC_IN, .TRACE_DST_IN, .CPU_REQ_IN, .CPU_WE_IN, .CPU_ACK_OUT,
    .CPU_RDATA_OUT, .SRAM_EN_OUT, .SRAM_WE_OUT, .SRAM_ADDR_OUT,
    .SRAM_WDATA_OUT, .SRAM_RDATA_IN, .TRACE_ON_OUT, .HALT_REQ_OUT);

// ===== dv/program_flow_trace_buffer_test.sv
// self-checking bench for the trace buffer
`timescale 1ns/1ps
module program_flow_trace_buffer_test
    import tbu_pkg::*;
;
    logic SYS_CLK_IN = 1'b0, RST_IN = 1'b1, PSEL_IN = 1'b0;
    logic PENABLE_IN = 1'b0, PWRITE_IN = 1'b0, CPU_REQ_IN = 1'b0;
    logic TRACE_BRANCH_IN = 1'b0, TRACE_EXC_IN = 1'b0, CPU_WE_IN = 1'b0;
    logic [31:0] PADDR_IN = 32'h0, PWDATA_IN = 32'h0, CPU_WDATA_IN = 32'h0;
    logic [31:0] TRACE_SRC_IN = 32'h0, TRACE_DST_IN = 32'h0;
    logic [12:0] CPU_ADDR_IN = 13'h0;
    logic [3:0] CPU_BE_IN = 4'hf; // whole words only
    logic [31:0] PRDATA_OUT, CPU_RDATA_OUT, SRAM_WDATA_OUT, SRAM_RDATA_IN;
    logic PREADY_OUT, PSLVERR_OUT, CPU_ACK_OUT, SRAM_EN_OUT, SRAM_WE_OUT;
    logic TRACE_ON_OUT, HALT_REQ_OUT;
    logic [3:0] SRAM_BE_OUT;
    logic [12:0] SRAM_ADDR_OUT;
    logic [31:0] rd; // last read data
    logic er; // last bus error
    int fails = 0, tests_run = 0, halts = 0;
    always #5 SYS_CLK_IN = ~SYS_CLK_IN;
    // halt pulses seen, one per watermark hit with auto halt set
    always @(posedge SYS_CLK_IN) if (HALT_REQ_OUT === 1'b1) halts++;
    tbu_top dut (.SYS_CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
        .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
        .TRACE_BRANCH_IN, .TRACE_EXC_IN, .TRACE_SRC_IN, .TRACE_DST_IN,
        .CPU_REQ_IN, .CPU_WE_IN, .CPU_BE_IN, .CPU_ADDR_IN, .CPU_WDATA_IN,
        .CPU_ACK_OUT, .CPU_RDATA_OUT, .SRAM_EN_OUT, .SRAM_WE_OUT,
        .SRAM_BE_OUT, .SRAM_ADDR_OUT, .SRAM_WDATA_OUT, .SRAM_RDATA_IN,
        .TRACE_ON_OUT, .HALT_REQ_OUT);
    tbu_sram_model sram (.clk_in(SYS_CLK_IN), .en_in(SRAM_EN_OUT),
        .we_in(SRAM_WE_OUT), .be_in(SRAM_BE_OUT), .addr_in(SRAM_ADDR_OUT),
        .wdata_in(SRAM_WDATA_OUT), .rdata_out(SRAM_RDATA_IN));
    task chk(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", n, exp, seen);
            fails++;
        end
    endtask : chk
    // one apb transfer, held until ready is sampled
    task apb(input logic w, input logic [31:0] a, wd);
        int n;
        @(posedge SYS_CLK_IN);
        PSEL_IN <= 1'b1;
        PWRITE_IN <= w;
        PADDR_IN <= TBU_BASE_ADDR + a;
        PWDATA_IN <= wd;
        @(posedge SYS_CLK_IN);
        PENABLE_IN <= 1'b1;
        n = 0;
        do
        begin
            @(posedge SYS_CLK_IN);
            n++;
        end
        while (PREADY_OUT !== 1'b1 && n < 20);
        if (n == 20) fails++;
        rd = PRDATA_OUT;
        er = PSLVERR_OUT;
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
    endtask : apb
    // processor access, held until acknowledged
    task cpu(input logic w, input logic [12:0] a, input logic [31:0] wd);
        int n;
        @(posedge SYS_CLK_IN);
        CPU_REQ_IN <= 1'b1;
        CPU_WE_IN <= w;
        CPU_ADDR_IN <= a;
        CPU_WDATA_IN <= wd;
        n = 0;
        do
        begin
            @(posedge SYS_CLK_IN);
            n++;
        end
        while (CPU_ACK_OUT !== 1'b1 && n < 30);
        if (n == 30) fails++;
        rd = CPU_RDATA_OUT;
        CPU_REQ_IN <= 1'b0;
    endtask : cpu
    // jump k: both, branch or exception by k mod 3
    task ev(input int k);
        @(posedge SYS_CLK_IN);
        TRACE_BRANCH_IN <= (k % 3 != 2);
        TRACE_EXC_IN <= (k % 3 != 1);
        TRACE_SRC_IN <= 32'h1001 + 32'h10 * k;
        TRACE_DST_IN <= 32'h2001 + 32'h10 * k;
        @(posedge SYS_CLK_IN);
        TRACE_BRANCH_IN <= 1'b0;
        TRACE_EXC_IN <= 1'b0;
        repeat (6) @(posedge SYS_CLK_IN);
    endtask : ev
    // packet of jump k at word a
    task pk(input int k, input logic [12:0] a, input logic st);
        logic [31:0] s, d;
        s = 32'h1001 + 32'h10 * k;
        d = 32'h2001 + 32'h10 * k;
        chk("head", sram.mem[a], {s[31:1], k % 3 != 1});
        chk("tail", sram.mem[a + 13'h1], {d[31:1], st});
    endtask : pk
    task end_of_test;
        $display("checks %0d errors %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (8) @(posedge SYS_CLK_IN);
        RST_IN <= 1'b0;
        apb(1'b1, 32'hc, 32'h0);
        apb(1'b0, 32'hc, 32'h0);
        chk("location", rd, 32'h2000_0000);
        apb(1'b0, 32'h10, 32'h0);
        chk("unmapped err", er, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 32'h0, 32'h100); // 16-byte region at 0x100
        apb(1'b1, 32'h4, 32'h8000_0000);
        @(posedge SYS_CLK_IN);
        chk("trace on", TRACE_ON_OUT, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            ev(k);
            pk(k, 13'h40 + 13'h2 * (k % 2), k == 0);
        end
        apb(1'b0, 32'h0, 32'h0);
        chk("position", rd, 32'h10c);
        apb(1'b1, 32'h8, 32'h103); // stop and halt at 0x100
        ev(3);
        pk(3, 13'h42, 1'b0);
        chk("auto stop", TRACE_ON_OUT, 32'h0);
        chk("halts", halts, 32'h1);
        apb(1'b0, 32'h8, 32'h0);
        chk("flow", rd, 32'h103);
        ev(4);
        pk(2, 13'h40, 1'b0);
        cpu(1'b1, 13'h10, 32'hcafe_f00d);
        apb(1'b1, 32'h4, 32'h8000_0000);
        // trace and processor collide on the SRAM
        fork
            ev(5);
            cpu(1'b0, 13'h10, 32'h0);
        join
        chk("cpu data", rd, 32'hcafe_f00d);
        pk(5, 13'h40, 1'b1);
        end_of_test();
    end
    // watchdog, far beyond the hundred or so cycles needed
    initial
    begin
        #200_000;
        fails++;
        end_of_test();
    end
endmodule : program_flow_trace_buffer_test
